// ### slpc_pkg.sv
package slpc_pkg;

  localparam int unsigned PTR_W  = 16;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;

  // Register offsets as seen on the serial register port.
  localparam logic [ADDR_W-1:0] REG_WR_PTR = 10'h2d0;
  localparam logic [ADDR_W-1:0] REG_RD_PTR = 10'h2d1;
  localparam logic [ADDR_W-1:0] REG_RD_ONE = 10'h2d2;
  localparam logic [ADDR_W-1:0] REG_SRC_1  = 10'h2d3;
  localparam logic [ADDR_W-1:0] REG_SRC_2  = 10'h2d4;
  localparam logic [ADDR_W-1:0] REG_SRC_3  = 10'h2d5;
  localparam logic [ADDR_W-1:0] REG_SRC_4  = 10'h2d6;

  localparam logic [PTR_W-1:0]  PTR_RST      = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_WRAP_CYC = 16'h0001;
  localparam logic [PTR_W-1:0]  PTR_WRAP_LIN = 16'h0000;
  localparam logic [DATA_W-1:0] SRC_RST      = 16'h0000;

  // Buffer mode, first configuration digit.
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_CYCLIC = 2'h1;
  localparam logic [1:0] MODE_LINEAR = 2'h2;
  localparam logic [1:0] MODE_CLEAR  = 2'h3;

  // Time stamp, second configuration digit.
  localparam logic [1:0] STAMP_NONE = 2'h0;
  localparam logic [1:0] STAMP_MDY  = 2'h1;
  localparam logic [1:0] STAMP_DMY  = 2'h2;
  localparam logic [1:0] STAMP_HMS  = 2'h3;

  localparam logic [2:0] CHANS_NONE = 3'h4;
  localparam logic [2:0] CHANS_HMS  = 3'h3;
  localparam logic [2:0] CHANS_DATE = 3'h2;

  // Installed memory size code and the sample counts it allows.
  localparam logic [1:0] MEM_32K   = 2'h0;
  localparam logic [1:0] MEM_64K   = 2'h1;
  localparam logic [1:0] MEM_512K  = 2'h2;
  localparam logic [1:0] MEM_1024K = 2'h3;
  localparam logic [PTR_W-1:0] MAX_32K  = 16'h0058;
  localparam logic [PTR_W-1:0] MAX_64K  = 16'h00d8;
  localparam logic [PTR_W-1:0] MAX_512K = 16'h07d8;
  localparam logic [PTR_W-1:0] MAX_1024K_DEF = 16'h0fa0;

  localparam logic [7:0] CHR_CR  = 8'h0d;
  localparam logic [7:0] CHR_LF  = 8'h0a;
  localparam logic [7:0] CHR_TAB = 8'h09;

endpackage

// ### slpc_ptr.sv
`timescale 1ns/1ps
module slpc_ptr #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_i,    // System clock.
  input  wire logic         rst_i,    // Asynchronous reset, active high.
  input  wire logic         ce_i,     // Clock enable.
  input  wire logic         clr_i,    // Clear to zero.
  input  wire logic         ld_i,     // Host load.
  input  wire logic [W-1:0] ld_val_i, // Host load value.
  input  wire logic         inc_i,    // Advance by one.
  input  wire logic [W-1:0] max_i,    // Highest sample number.
  input  wire logic [W-1:0] wrap_i,   // Value taken after the highest.
  output logic      [W-1:0] q_o,      // Current pointer.
  output logic      [W-1:0] next_o    // Value after one advance.
);

  logic [W-1:0] ptr_q;
  logic [W-1:0] ptr_d;

  if (W < 8) begin : g_chk
    $error("slpc_ptr: pointer width too small");
  end

  assign next_o = (ptr_q >= max_i) ? wrap_i : ptr_q + W'(1);
  assign q_o    = ptr_q;

  // The whole word changes in one edge, so a host read never sees half an update.
  always_comb begin
    ptr_d = ptr_q;
    if (clr_i) begin
      ptr_d = '0; // RQ11
    end else if (ld_i) begin
      ptr_d = ld_val_i; // RQ5
    end else if (inc_i) begin
      ptr_d = next_o; // RQ24
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_q <= '0;
    end else if (ce_i) begin
      ptr_q <= ptr_d;
    end
  end

endmodule // slpc_ptr

// ### slpc_fmt.sv
`timescale 1ns/1ps
module slpc_fmt
  import slpc_pkg::*;
(
  input  wire logic       clk_i,        // System clock.
  input  wire logic       rst_i,        // Asynchronous reset, active high.
  input  wire logic       ce_i,         // Clock enable.
  input  wire logic       sheet_i,      // High: spreadsheet style, low: print style.
  input  wire logic       par_done_i,   // Pulse: one parameter of a sample was sent.
  input  wire logic       par_last_i,   // With par_done_i: it was the last one.
  input  wire logic       tx_ready_i,   // Serial transmitter takes a byte.
  output logic            tx_valid_o,   // Separator byte valid.
  output logic      [7:0] tx_byte_o,    // Separator byte.
  output logic            busy_o        // Separator still pending.
);

  typedef enum logic [1:0] {F_IDLE, F_TAB, F_CR, F_LF} slpc_fmt_t;

  slpc_fmt_t  st_q;
  slpc_fmt_t  st_d;
  logic       vld_q;
  logic       vld_d;
  logic [7:0] byte_q;
  logic [7:0] byte_d;

  always_comb begin
    st_d   = st_q;
    vld_d  = vld_q;
    byte_d = byte_q;
    unique case (st_q)
      F_IDLE: begin
        if (par_done_i) begin
          vld_d = 1'b1;
          if (sheet_i && !par_last_i) begin
            st_d   = F_TAB; // RQ20
            byte_d = CHR_TAB;
          end else begin
            st_d   = F_CR; // RQ19
            byte_d = CHR_CR;
          end
        end
      end
      F_TAB: begin
        if (tx_ready_i) begin
          st_d  = F_IDLE;
          vld_d = 1'b0;
        end
      end
      F_CR: begin
        if (tx_ready_i) begin
          st_d   = F_LF; // RQ19
          byte_d = CHR_LF;
        end
      end
      F_LF: begin
        if (tx_ready_i) begin
          st_d  = F_IDLE;
          vld_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= F_IDLE;
      vld_q  <= 1'b0;
      byte_q <= 8'h00;
    end else if (ce_i) begin
      st_q   <= st_d;
      vld_q  <= vld_d;
      byte_q <= byte_d;
    end
  end

  assign tx_valid_o = vld_q;
  assign tx_byte_o  = byte_q;
  assign busy_o     = (st_q != F_IDLE);

endmodule // slpc_fmt

// ### slpc_top.sv
// What this block does
// RQ1: Sixteen-bit write pointer names latest sample, starts at zero, advances per log.
// RQ2: Before storing, if next write meets read pointer, drop sample and halt.
// RQ3: At the highest sample number pointers wrap or logging stops, per mode.
// RQ4: Sixteen-bit read pointer names latest sample read, advances per log read.
// RQ5: Host may read and overwrite both pointers as ordinary registers.
// RQ6: Host writes only pointer values inside the installed memory range; the code loads any written value without a range check.
// RQ7: Mode one selects the cyclic buffer; write pointer advances each sample.
// RQ8: Cyclic buffer full overwrites oldest and wraps storage to sample one.
// RQ9: Mode two selects the linear buffer; write pointer advances each sample.
// RQ10: Linear buffer full stops logging until pointers are reset.
// RQ11: Mode three plus program button clears both pointers, mode reverts.
// RQ12: Pointer reset changes only pointers, never the stored sample contents.
// RQ13: Four source-select registers name the values captured into each sample.
// RQ14: Source-select registers reachable only over the serial register port.
// RQ15: Highest sample number follows installed memory size.
// RQ16: Setpoint, program button or external switch triggers a sample.
// RQ17: Second digit selects none, date-time month first, day first, or time stamp.
// RQ18: Channel count is four, three or two according to the stamp choice.
// RQ19: Print style ends each parameter with carriage return and line feed.
// RQ20: Spreadsheet style puts a whole sample on a line, tab separated.
// RQ21: All stamps come from the real-time clock.
// RQ22: Single-sample read reports no data when equal, else advances and sends.
// RQ23: Host write to single-sample register takes a sample when a mode is on.
// RQ24: Pointers update in one edge so reads never see partial values.
`timescale 1ns/1ps
module slpc_top
  import slpc_pkg::*;
#(
  parameter logic [PTR_W-1:0] MAX_1024K = MAX_1024K_DEF
) (
  input  wire logic              clk_i,        // System clock, 40 MHz.
  input  wire logic              rst_i,        // Asynchronous reset, active high.
  input  wire logic              ce_i,         // Clock enable, freezes all state when low.
  input  wire logic              reg_rd_i,     // Serial port register read pulse.
  input  wire logic              reg_wr_i,     // Serial port register write pulse.
  input  wire logic [ADDR_W-1:0] reg_addr_i,   // Register number.
  input  wire logic [DATA_W-1:0] reg_wdata_i,  // Write data.
  output logic      [DATA_W-1:0] reg_rdata_o,  // Read data.
  output logic                   reg_ack_o,    // Access done pulse.
  output logic                   nodata_o,     // Pulse: single read found no new sample.
  input  wire logic              cfg_wr_i,     // Configuration write pulse.
  input  wire logic [1:0]        cfg_mode_i,   // Buffer mode digit.
  input  wire logic [1:0]        cfg_stamp_i,  // Time stamp digit.
  input  wire logic              cfg_sheet_i,  // Spreadsheet style when high.
  output logic      [1:0]        mode_o,       // Current buffer mode.
  input  wire logic              setpoint_i,   // Setpoint trigger pulse, same clock.
  input  wire logic              prog_btn_i,   // Program button pin, high when pressed.
  input  wire logic              ext_sw_i,     // External switch pin, high when closed.
  input  wire logic [1:0]        mem_sel_i,    // Installed memory size pins.
  output logic                   log_req_o,    // Pulse: store a sample.
  output logic      [PTR_W-1:0]  log_addr_o,   // Sample number to store at.
  output logic      [2:0]        log_chans_o,  // Channels in the sample.
  output logic      [1:0]        log_stamp_o,  // Stamp format of the sample.
  output logic                   rtc_latch_o,  // Pulse: take stamp from the real-time clock.
  output logic                   log_drop_o,   // Pulse: trigger discarded.
  output logic                   fetch_req_o,  // Pulse: send a stored sample.
  output logic      [PTR_W-1:0]  fetch_addr_o, // Sample number to send.
  output logic      [DATA_W-1:0] src1_o,       // First source register number.
  output logic      [DATA_W-1:0] src2_o,       // Second source register number.
  output logic      [DATA_W-1:0] src3_o,       // Third source register number.
  output logic      [DATA_W-1:0] src4_o,       // Fourth source register number.
  input  wire logic              par_done_i,   // Pulse: one parameter sent.
  input  wire logic              par_last_i,   // With par_done_i: last parameter.
  input  wire logic              tx_ready_i,   // Transmitter takes a byte.
  output logic                   tx_valid_o,   // Separator byte valid.
  output logic      [7:0]        tx_byte_o     // Separator byte.
);

  if (PTR_W != DATA_W) begin : g_chk
    $error("slpc_top: pointers must fill a register");
  end

  // Pin synchronisers; the first stage feeds only the second.
  logic [1:0] btn_s1_q, btn_s2_q, btn_s3_q;
  logic [1:0] btn_s1_d, btn_s2_d, btn_s3_d;
  logic [1:0] mem_s1_q, mem_s2_q;

  always_comb begin
    btn_s1_d = {ext_sw_i, prog_btn_i};
    btn_s2_d = btn_s1_q;
    btn_s3_d = btn_s2_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      btn_s1_q <= 2'h0;
      btn_s2_q <= 2'h0;
      btn_s3_q <= 2'h0;
      mem_s1_q <= MEM_32K;
      mem_s2_q <= MEM_32K;
    end else if (ce_i) begin
      btn_s1_q <= btn_s1_d;
      btn_s2_q <= btn_s2_d;
      btn_s3_q <= btn_s3_d;
      mem_s1_q <= mem_sel_i;
      mem_s2_q <= mem_s1_q;
    end
  end

  logic prog_rise;
  logic ext_rise;
  assign prog_rise = btn_s2_q[0] & ~btn_s3_q[0];
  assign ext_rise  = btn_s2_q[1] & ~btn_s3_q[1];

  // Configuration and source-select state.
  logic [1:0]        mode_q, mode_d, prev_mode_q, prev_mode_d;
  logic [1:0]        stamp_q, stamp_d;
  logic              sheet_q, sheet_d;
  logic [DATA_W-1:0] src_q [4];
  logic [DATA_W-1:0] src_d [4];

  logic [PTR_W-1:0] max_cnt;
  logic [PTR_W-1:0] wrap_to;
  logic [PTR_W-1:0] wp, wp_next, rp, rp_next;
  logic             mode_on;
  logic             lin_full;
  logic             collide;
  logic             trig;
  logic             log_go;
  logic             rd_one;
  logic             rd_go;
  logic             ptr_clr;
  logic             wp_ld, rp_ld;
  logic [2:0]       chans;

  always_comb begin
    unique case (mem_s2_q)
      MEM_32K:  max_cnt = MAX_32K; // RQ15
      MEM_64K:  max_cnt = MAX_64K;
      MEM_512K: max_cnt = MAX_512K;
      default:  max_cnt = MAX_1024K;
    endcase
  end

  always_comb begin
    unique case (stamp_q)
      STAMP_NONE: chans = CHANS_NONE; // RQ18
      STAMP_HMS:  chans = CHANS_HMS;
      default:    chans = CHANS_DATE;
    endcase
  end

  assign mode_on  = (mode_q == MODE_CYCLIC) || (mode_q == MODE_LINEAR); // RQ7 RQ9
  assign wrap_to  = (mode_q == MODE_CYCLIC) ? PTR_WRAP_CYC : PTR_WRAP_LIN; // RQ8 RQ3
  assign lin_full = (mode_q == MODE_LINEAR) && (wp >= max_cnt); // RQ10
  assign collide  = (wp_next == rp); // RQ2
  // Trigger sources; a host write to the single-sample register counts as one.
  assign trig     = setpoint_i | ext_rise | (prog_rise & mode_on)
                  | (reg_wr_i & (reg_addr_i == REG_RD_ONE)); // RQ16 RQ23
  assign log_go   = trig & mode_on & ~lin_full & ~collide; // RQ2 RQ3
  assign rd_one   = reg_rd_i & (reg_addr_i == REG_RD_ONE);
  assign rd_go    = rd_one & (rp != wp); // RQ22
  // Only the pointers are cleared; stored samples stay in memory untouched.
  assign ptr_clr  = prog_rise & (mode_q == MODE_CLEAR); // RQ11 RQ12
  assign wp_ld    = reg_wr_i & (reg_addr_i == REG_WR_PTR); // RQ5
  assign rp_ld    = reg_wr_i & (reg_addr_i == REG_RD_PTR); // RQ5

  always_comb begin
    mode_d      = mode_q;
    prev_mode_d = prev_mode_q;
    stamp_d     = stamp_q;
    sheet_d     = sheet_q;
    src_d       = src_q;
    if (cfg_wr_i) begin
      mode_d  = cfg_mode_i;
      stamp_d = cfg_stamp_i; // RQ17
      sheet_d = cfg_sheet_i;
      if (cfg_mode_i == MODE_CLEAR && mode_q != MODE_CLEAR) begin
        prev_mode_d = mode_q;
      end
    end else if (ptr_clr) begin
      mode_d = prev_mode_q; // RQ11
    end
    // Only the serial register port reaches these; no panel path exists.
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_SRC_1: src_d[0] = reg_wdata_i; // RQ13 RQ14
        REG_SRC_2: src_d[1] = reg_wdata_i;
        REG_SRC_3: src_d[2] = reg_wdata_i;
        REG_SRC_4: src_d[3] = reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q      <= MODE_OFF;
      prev_mode_q <= MODE_OFF;
      stamp_q     <= STAMP_NONE;
      sheet_q     <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        src_q[i] <= SRC_RST;
      end
    end else if (ce_i) begin
      mode_q      <= mode_d;
      prev_mode_q <= prev_mode_d;
      stamp_q     <= stamp_d;
      sheet_q     <= sheet_d;
      src_q       <= src_d;
    end
  end

  slpc_ptr #(.W(PTR_W)) u_wr_ptr (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .clr_i    (ptr_clr),
    .ld_i     (wp_ld),
    .ld_val_i (reg_wdata_i),
    .inc_i    (log_go), // RQ1
    .max_i    (max_cnt),
    .wrap_i   (wrap_to),
    .q_o      (wp),
    .next_o   (wp_next)
  );

  slpc_ptr #(.W(PTR_W)) u_rd_ptr (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .clr_i    (ptr_clr),
    .ld_i     (rp_ld),
    .ld_val_i (reg_wdata_i),
    .inc_i    (rd_go), // RQ4
    .max_i    (max_cnt),
    .wrap_i   (wrap_to),
    .q_o      (rp),
    .next_o   (rp_next)
  );

  // Registered outputs.
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              ack_q, ack_d, nodata_q, nodata_d;
  logic              lreq_q, lreq_d, rtc_q, rtc_d, drop_q, drop_d, freq_q, freq_d;
  logic [PTR_W-1:0]  laddr_q, laddr_d, faddr_q, faddr_d;
  logic [2:0]        lch_q, lch_d;
  logic [1:0]        lst_q, lst_d;

  always_comb begin
    ack_d    = reg_rd_i | reg_wr_i;
    rdata_d  = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_WR_PTR: rdata_d = wp; // RQ5 RQ24
        REG_RD_PTR: rdata_d = rp;
        REG_RD_ONE: rdata_d = rd_go ? rp_next : '0;
        REG_SRC_1:  rdata_d = src_q[0];
        REG_SRC_2:  rdata_d = src_q[1];
        REG_SRC_3:  rdata_d = src_q[2];
        REG_SRC_4:  rdata_d = src_q[3];
        default:    rdata_d = '0;
      endcase
    end
    nodata_d = rd_one & ~rd_go; // RQ22
    freq_d   = rd_go; // RQ22
    faddr_d  = rd_go ? rp_next : faddr_q;
    lreq_d   = log_go;
    laddr_d  = log_go ? wp_next : laddr_q;
    lch_d    = log_go ? chans : lch_q;
    lst_d    = log_go ? stamp_q : lst_q;
    rtc_d    = log_go & (stamp_q != STAMP_NONE); // RQ21
    drop_d   = trig & mode_on & ~log_go; // RQ2 RQ10
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q  <= '0;
      ack_q    <= 1'b0;
      nodata_q <= 1'b0;
      freq_q   <= 1'b0;
      faddr_q  <= PTR_RST;
      lreq_q   <= 1'b0;
      laddr_q  <= PTR_RST;
      lch_q    <= CHANS_NONE;
      lst_q    <= STAMP_NONE;
      rtc_q    <= 1'b0;
      drop_q   <= 1'b0;
    end else if (ce_i) begin
      rdata_q  <= rdata_d;
      ack_q    <= ack_d;
      nodata_q <= nodata_d;
      freq_q   <= freq_d;
      faddr_q  <= faddr_d;
      lreq_q   <= lreq_d;
      laddr_q  <= laddr_d;
      lch_q    <= lch_d;
      lst_q    <= lst_d;
      rtc_q    <= rtc_d;
      drop_q   <= drop_d;
    end
  end

  slpc_fmt u_fmt (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .sheet_i    (sheet_q), // RQ19 RQ20
    .par_done_i (par_done_i),
    .par_last_i (par_last_i),
    .tx_ready_i (tx_ready_i),
    .tx_valid_o (tx_valid_o),
    .tx_byte_o  (tx_byte_o),
    .busy_o     ()
  );

  assign reg_rdata_o  = rdata_q;
  assign reg_ack_o    = ack_q;
  assign nodata_o     = nodata_q;
  assign mode_o       = mode_q;
  assign log_req_o    = lreq_q;
  assign log_addr_o   = laddr_q;
  assign log_chans_o  = lch_q;
  assign log_stamp_o  = lst_q;
  assign rtc_latch_o  = rtc_q;
  assign log_drop_o   = drop_q;
  assign fetch_req_o  = freq_q;
  assign fetch_addr_o = faddr_q;
  assign src1_o       = src_q[0];
  assign src2_o       = src_q[1];
  assign src3_o       = src_q[2];
  assign src4_o       = src_q[3];

endmodule // slpc_top

// ### slpc_props.sv
`timescale 1ns/1ps
module slpc_props
  import slpc_pkg::*;
(
  input wire logic              clk_i,        // Clock.
  input wire logic              rst_i,        // Reset.
  input wire logic              ce_i,         // Enable.
  input wire logic              reg_rd_i,     // Read.
  input wire logic              reg_wr_i,     // Write.
  input wire logic [ADDR_W-1:0] reg_addr_i,   // Address.
  input wire logic              reg_ack_o,    // Ack.
  input wire logic [DATA_W-1:0] reg_rdata_o,  // Read data.
  input wire logic              nodata_o,     // No data.
  input wire logic              fetch_req_o,  // Fetch.
  input wire logic [PTR_W-1:0]  fetch_addr_o, // Fetch address.
  input wire logic              setpoint_i,   // Trigger.
  input wire logic [1:0]        mode_o,       // Mode.
  input wire logic              log_req_o,    // Store.
  input wire logic              log_drop_o,   // Drop.
  input wire logic [2:0]        log_chans_o,  // Channels.
  input wire logic [1:0]        log_stamp_o,  // Stamp.
  input wire logic              rtc_latch_o,  // Clock latch.
  input wire logic              tx_valid_o,   // Byte valid.
  input wire logic [7:0]        tx_byte_o,    // Byte.
  input wire logic              tx_ready_i    // Byte taken.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_follows_a: assert property ((reg_rd_i || reg_wr_i) && ce_i |=> reg_ack_o)
    else $error("access not acknowledged");
  nodata_cause_a: assert property (nodata_o |-> $past(reg_rd_i && reg_addr_i == REG_RD_ONE) && !fetch_req_o)
    else $error("stray no-data pulse");
  fetch_data_a: assert property (fetch_req_o |-> reg_ack_o && reg_rdata_o == fetch_addr_o)
    else $error("fetch without matching read data");
  trig_answer_a: assert property (setpoint_i && ce_i && (mode_o == MODE_CYCLIC || mode_o == MODE_LINEAR)
    |=> log_req_o != log_drop_o) else $error("trigger not answered");
  mode_off_quiet_a: assert property ((mode_o == MODE_OFF || mode_o == MODE_CLEAR) |=> !log_req_o && !log_drop_o)
    else $error("logging while disabled");
  chans_match_a: assert property (log_req_o |-> log_chans_o == (log_stamp_o == STAMP_NONE ? CHANS_NONE :
    (log_stamp_o == STAMP_HMS ? CHANS_HMS : CHANS_DATE))) else $error("channel count wrong");
  rtc_with_log_a: assert property ((rtc_latch_o || log_req_o) |-> log_req_o &&
    rtc_latch_o == (log_stamp_o != STAMP_NONE)) else $error("clock latch wrong");
  cr_then_lf_a: assert property (tx_valid_o && tx_ready_i && tx_byte_o == CHR_CR |=>
    tx_valid_o && tx_byte_o == CHR_LF) else $error("line feed missing");
endmodule // slpc_props

bind slpc_top slpc_props slpc_props_i (.clk_i, .rst_i, .ce_i, .reg_rd_i, .reg_wr_i, .reg_addr_i, .reg_ack_o,
  .reg_rdata_o, .nodata_o, .fetch_req_o, .fetch_addr_o, .setpoint_i, .mode_o, .log_req_o, .log_drop_o,
  .log_chans_o, .log_stamp_o, .rtc_latch_o, .tx_valid_o, .tx_byte_o, .tx_ready_i);

// ### slpc_printer.sv
`timescale 1ns/1ps
module slpc_printer (
  input  wire logic       clk_i,      // Clock.
  input  wire logic       rst_i,      // Reset.
  input  wire logic       stall_i,    // Slow acceptance.
  input  wire logic       tx_valid_i, // Byte offered.
  input  wire logic [7:0] tx_byte_i,  // Byte offered.
  output logic            tx_ready_o  // Byte taken.
);
  logic [7:0] rx_q[$];

  // A slow printer takes a byte every other cycle, so the sender must hold it.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) tx_ready_o <= 1'b0;
    else tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
  end

  always @(posedge clk_i) begin
    if (!rst_i && tx_valid_i && tx_ready_o) rx_q.push_back(tx_byte_i);
  end
endmodule // slpc_printer

// ### slpc_bench.sv
`timescale 1ns/1ps
module slpc_bench import slpc_pkg::*;;
  logic              clk_i = 1'b0;
  logic              rst_i, ce_i, reg_rd_i, reg_wr_i, cfg_wr_i, cfg_sheet_i, setpoint_i, prog_btn_i, ext_sw_i;
  logic              par_done_i, par_last_i, stall, reg_ack_o, nodata_o, log_req_o, rtc_latch_o, log_drop_o;
  logic              fetch_req_o, tx_ready_i, tx_valid_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, src1_o, src2_o, src3_o, src4_o;
  logic [PTR_W-1:0]  log_addr_o, fetch_addr_o;
  logic [1:0]        cfg_mode_i, cfg_stamp_i, mode_o, mem_sel_i, log_stamp_o;
  logic [2:0]        log_chans_o;
  logic [7:0]        tx_byte_o;
  int                fails = 0;
  int                n_compared = 0;

  always #12.5 clk_i = ~clk_i;

  slpc_top #(.MAX_1024K(16'h0008)) slpc_top_i (.clk_i, .rst_i, .ce_i, .reg_rd_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .nodata_o, .cfg_wr_i, .cfg_mode_i, .cfg_stamp_i, .cfg_sheet_i,
    .mode_o, .setpoint_i, .prog_btn_i, .ext_sw_i, .mem_sel_i, .log_req_o, .log_addr_o, .log_chans_o,
    .log_stamp_o, .rtc_latch_o, .log_drop_o, .fetch_req_o, .fetch_addr_o, .src1_o, .src2_o, .src3_o, .src4_o,
    .par_done_i, .par_last_i, .tx_ready_i, .tx_valid_o, .tx_byte_o);
  slpc_printer slpc_printer_i (.clk_i, .rst_i, .stall_i(stall), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
    .tx_ready_o(tx_ready_i));

  task test_done;
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The answer is fixed at one cycle after the request is taken.
  task acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] e);
    @(posedge clk_i);
    reg_wr_i <= wr;
    reg_rd_i <= !wr;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_ack_o, 1'b1);
    if (reg_ack_o !== 1'b1) test_done();
    if (!wr) chk(reg_rdata_o, e);
  endtask

  task cfg(input logic [1:0] m, input logic [1:0] s, input logic sh);
    @(posedge clk_i);
    cfg_wr_i <= 1'b1;
    cfg_mode_i <= m;
    cfg_stamp_i <= s;
    cfg_sheet_i <= sh;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    #1;
    chk(mode_o, m);
  endtask

  task trig(input int kind, input logic er, input logic ed, input logic [15:0] ea, input logic [2:0] ec,
            input logic erl);
    int   k;
    logic rq;
    logic dp;
    rq = 1'b0;
    dp = 1'b0;
    @(posedge clk_i);
    case (kind)
      0: setpoint_i <= 1'b1;
      1: begin
        reg_wr_i <= 1'b1;
        reg_addr_i <= REG_RD_ONE;
      end
      default: ext_sw_i <= 1'b1;
    endcase
    @(posedge clk_i);
    setpoint_i <= 1'b0;
    reg_wr_i <= 1'b0;
    for (k = 0; k < 8 && !(rq || dp); k++) begin
      #1;
      rq = log_req_o;
      dp = log_drop_o;
      if (!(rq || dp)) @(posedge clk_i);
    end
    chk({rq, dp}, {er, ed});
    if (er) begin
      chk(log_addr_o, ea);
      chk(log_chans_o, ec);
      chk(rtc_latch_o, erl);
      chk(log_stamp_o, cfg_stamp_i);
    end
    @(posedge clk_i);
    ext_sw_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task par(input logic last, input int n);
    int k;
    @(posedge clk_i);
    par_done_i <= 1'b1;
    par_last_i <= last;
    @(posedge clk_i);
    par_done_i <= 1'b0;
    for (k = 0; k < 40 && slpc_printer_i.rx_q.size() < n; k++) @(posedge clk_i);
    chk(16'(slpc_printer_i.rx_q.size()), 16'(n));
    if (slpc_printer_i.rx_q.size() < n) test_done();
    repeat (2) @(posedge clk_i);
  endtask

  initial begin
    int         i;
    logic [7:0] sep [5];
    sep = '{CHR_TAB, CHR_CR, CHR_LF, CHR_CR, CHR_LF};
    {rst_i, ce_i, reg_rd_i, reg_wr_i, cfg_wr_i, cfg_sheet_i, setpoint_i, prog_btn_i} = 8'h c0;
    {ext_sw_i, par_done_i, par_last_i, stall} = 4'h1;
    {reg_addr_i, reg_wdata_i, cfg_mode_i, cfg_stamp_i, mem_sel_i} = {26'h0, 2'h0, 2'h0, MEM_1024K};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i <= 7; i++) acc(1'b0, REG_WR_PTR + 10'(i), 16'h0000, PTR_RST);
    for (i = 0; i < 4; i++) acc(1'b1, REG_SRC_1 + 10'(i), 16'h0a50 + 16'(i), 16'h0000);
    acc(1'b1, 10'h2d7, 16'hffff, 16'h0000);
    for (i = 0; i < 4; i++) acc(1'b0, REG_SRC_1 + 10'(i), 16'h0000, 16'h0a50 + 16'(i));
    chk(src1_o, 16'h0a50);
    chk(src4_o, 16'h0a53);
    chk(src2_o, 16'h0a51);
    chk(src3_o, 16'h0a52);
    acc(1'b0, 10'h2d7, 16'h0000, 16'h0000);
    acc(1'b1, REG_WR_PTR, 16'h0005, 16'h0000);
    acc(1'b1, REG_RD_PTR, 16'h0006, 16'h0000);
    acc(1'b0, REG_WR_PTR, 16'h0000, 16'h0005);
    acc(1'b0, REG_RD_PTR, 16'h0000, 16'h0006);
    acc(1'b1, REG_WR_PTR, 16'h0000, 16'h0000);
    acc(1'b1, REG_RD_PTR, 16'h0000, 16'h0000);
    trig(0, 1'b0, 1'b0, 16'h0000, 3'h0, 1'b0);
    trig(1, 1'b0, 1'b0, 16'h0000, 3'h0, 1'b0);
    cfg(MODE_CYCLIC, STAMP_HMS, 1'b0);
    for (i = 1; i <= 9; i++) trig(0, 1'b1, 1'b0, (i == 9) ? 16'h0001 : 16'(i), CHANS_HMS, 1'b1);
    acc(1'b1, REG_RD_PTR, 16'h0003, 16'h0000);
    trig(0, 1'b1, 1'b0, 16'h0002, CHANS_HMS, 1'b1);
    trig(0, 1'b0, 1'b1, 16'h0000, 3'h0, 1'b0);
    acc(1'b0, REG_WR_PTR, 16'h0000, 16'h0002);
    acc(1'b1, REG_RD_PTR, 16'h0000, 16'h0000);
    for (i = 1; i <= 2; i++) begin
      acc(1'b0, REG_RD_ONE, 16'h0000, 16'(i));
      chk(fetch_addr_o, 16'(i));
      chk(fetch_req_o, 1'b1);
    end
    acc(1'b0, REG_RD_ONE, 16'h0000, 16'h0000);
    chk(nodata_o, 1'b1);
    @(posedge clk_i) mem_sel_i <= MEM_32K;
    acc(1'b1, REG_WR_PTR, MAX_32K, 16'h0000);
    trig(0, 1'b1, 1'b0, 16'h0001, CHANS_HMS, 1'b1);
    @(posedge clk_i) mem_sel_i <= MEM_1024K;
    acc(1'b1, REG_WR_PTR, 16'h0007, 16'h0000);
    acc(1'b1, REG_RD_PTR, 16'h0000, 16'h0000);
    cfg(MODE_LINEAR, STAMP_NONE, 1'b1);
    trig(1, 1'b1, 1'b0, 16'h0008, CHANS_NONE, 1'b0);
    trig(0, 1'b0, 1'b1, 16'h0000, 3'h0, 1'b0);
    acc(1'b1, REG_WR_PTR, 16'h0000, 16'h0000);
    trig(2, 1'b1, 1'b0, 16'h0001, CHANS_NONE, 1'b0);
    cfg(MODE_LINEAR, STAMP_DMY, 1'b1);
    trig(0, 1'b1, 1'b0, 16'h0002, CHANS_DATE, 1'b1);
    cfg(MODE_LINEAR, STAMP_MDY, 1'b1);
    trig(0, 1'b1, 1'b0, 16'h0003, CHANS_DATE, 1'b1);
    cfg(MODE_CLEAR, STAMP_MDY, 1'b1);
    trig(0, 1'b0, 1'b0, 16'h0000, 3'h0, 1'b0);
    @(posedge clk_i);
    prog_btn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    prog_btn_i <= 1'b0;
    #1;
    chk(mode_o, MODE_LINEAR);
    acc(1'b0, REG_WR_PTR, 16'h0000, PTR_RST);
    acc(1'b0, REG_RD_PTR, 16'h0000, PTR_RST);
    par(1'b0, 1);
    par(1'b1, 3);
    cfg(MODE_LINEAR, STAMP_NONE, 1'b0);
    par(1'b0, 5);
    for (i = 0; i < 5; i++) chk(slpc_printer_i.rx_q[i], sep[i]);
    test_done();
  end
endmodule // slpc_bench
